// file: rtl/diag_record_pkg.sv
package diag_record_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PRESCALE_W = 5;
  localparam int TICKER_W = 32;

  // ---------------------------------------------------------------------------
  // Channels and record sets
  // ---------------------------------------------------------------------------
  localparam int NUM_CHANNELS = 4;
  localparam logic [7:0] RECORD_SET_SHORT = 8'h00;
  localparam logic [7:0] RECORD_SET_FULL = 8'h01;
  localparam logic [4:0] SHORT_RECORD_LEN = 5'h04;
  localparam logic [4:0] FULL_RECORD_LEN = 5'h14;

  // ---------------------------------------------------------------------------
  // Byte positions within the record
  // ---------------------------------------------------------------------------
  localparam logic [4:0] IDX_GENERAL_DIAG = 5'h00;
  localparam logic [4:0] IDX_MODULE_INFO = 5'h01;
  localparam logic [4:0] IDX_RESERVED_C = 5'h02;
  localparam logic [4:0] IDX_INTERNAL_DIAG = 5'h03;
  localparam logic [4:0] IDX_CHANNEL_TYPE = 5'h04;
  localparam logic [4:0] IDX_DIAG_BITS = 5'h05;
  localparam logic [4:0] IDX_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] IDX_GROUP_ERRORS = 5'h07;
  localparam logic [4:0] IDX_CHANNEL_ERROR_0 = 5'h08;
  localparam logic [4:0] IDX_TIMESTAMP_0 = 5'h10;
  localparam logic [4:0] IDX_TIMESTAMP_1 = 5'h11;
  localparam logic [4:0] IDX_TIMESTAMP_2 = 5'h12;
  localparam logic [4:0] IDX_TIMESTAMP_3 = 5'h13;

  // ---------------------------------------------------------------------------
  // Constant field values
  // ---------------------------------------------------------------------------
  localparam logic [3:0] MODULE_CLASS_ANALOG = 4'h5;
  localparam logic [6:0] CHANNEL_TYPE_AO = 7'h73;
  localparam logic [7:0] DIAG_BITS_PER_CHANNEL = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT = 8'h04;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ---------------------------------------------------------------------------
  // Bit positions
  // ---------------------------------------------------------------------------
  localparam int MODINFO_CHAN_INFO_BIT = 4;
  localparam int INTDIAG_OVERFLOW_BIT = 3;
  localparam int INTDIAG_COMM_BIT = 4;
  localparam int CHANNEL_CONFIG_BIT = 0;
  localparam int CHANNEL_SHORT_BIT = 3;
  localparam int GEN_ANY_ERROR_BIT = 0;
  localparam int GEN_INTERNAL_BIT = 1;
  localparam int GEN_EXTERNAL_BIT = 2;
  localparam int GEN_CHANNEL_BIT = 3;
  localparam int GEN_PARAM_BIT = 7;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [7:0] record_set;
    logic [4:0] index;
  } record_req_s;

  typedef struct packed {
    logic refused;
    logic [7:0] data;
  } record_resp_s;

endpackage : diag_record_pkg

// file: rtl/us_ticker.sv
`timescale 1ns/100ps
module us_ticker (
  input wire logic clk,
  input wire logic reset,
  output logic [diag_record_pkg::TICKER_W-1:0] count
);

  logic [diag_record_pkg::PRESCALE_W-1:0] prescale;
  logic tick;

  assign tick = (prescale ==
    diag_record_pkg::PRESCALE_W'(diag_record_pkg::TICK_CYCLES - 1));

  // ---------------------------------------------------------------------------
  // Microsecond prescaler
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || tick) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Free-running count
  // ---------------------------------------------------------------------------
  // start from zero
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end

endmodule : us_ticker

// file: rtl/analog_output_diag_record.sv
`timescale 1ns/100ps
module analog_output_diag_record (
  input wire logic clk,
  input wire logic reset,
  input wire logic [diag_record_pkg::NUM_CHANNELS-1:0] config_error,
  input wire logic [diag_record_pkg::NUM_CHANNELS-1:0] short_to_ground,
  input wire logic buffer_overflow,
  input wire logic comm_error,
  input wire logic req_valid,
  input wire diag_record_pkg::record_req_s req,
  output logic resp_valid,
  output diag_record_pkg::record_resp_s resp,
  output logic [diag_record_pkg::NUM_CHANNELS-1:0] channel_led,
  output logic group_led
);

  localparam int N = diag_record_pkg::NUM_CHANNELS;

  logic [N-1:0] cfg_meta;
  logic [N-1:0] cfg_sync;
  logic [N-1:0] short_meta;
  logic [N-1:0] short_sync;
  logic overflow_flag;
  logic comm_flag;
  logic [7:0] channel_error [N];
  logic [N-1:0] channel_any;
  logic [7:0] module_info;
  logic [7:0] internal_diag;
  logic [7:0] channel_type;
  logic [7:0] group_errors;
  logic [7:0] general_diag;
  logic [2*N+1:0] error_vector;
  logic [2*N+1:0] error_prev;
  logic new_event;
  logic [diag_record_pkg::TICKER_W-1:0] ticker;
  logic [diag_record_pkg::TICKER_W-1:0] diag_timestamp;
  logic set_ok;
  logic index_ok;
  logic accept_read;
  logic clear_internal;
  logic [7:0] next_data;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_meta <= '0;
      cfg_sync <= '0;
      short_meta <= '0;
      short_sync <= '0;
    end else begin
      cfg_meta <= config_error;
      cfg_sync <= cfg_meta;
      short_meta <= short_to_ground;
      short_sync <= short_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Microsecond ticker
  // ---------------------------------------------------------------------------
  us_ticker ticker_unit (
    .clk(clk),
    .reset(reset),
    .count(ticker)
  );

  // ---------------------------------------------------------------------------
  // Per-channel error bytes
  // ---------------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < N; ch++) begin : g_channel
      always_comb begin
        channel_error[ch] = diag_record_pkg::BYTE_ZERO;
        channel_error[ch][diag_record_pkg::CHANNEL_CONFIG_BIT] = cfg_sync[ch];
        channel_error[ch][diag_record_pkg::CHANNEL_SHORT_BIT] = short_sync[ch];
      end
      assign channel_any[ch] = cfg_sync[ch] | short_sync[ch];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Internal diagnostic flags
  // ---------------------------------------------------------------------------
  // The flags are sticky and clear when the internal byte is read; a new event
  // in the clearing cycle keeps its flag set.
  // overflow flag set
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_flag <= 1'b0;
    end else if (buffer_overflow) begin
      overflow_flag <= 1'b1;
    end else if (clear_internal) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      comm_flag <= 1'b0;
    end else if (comm_error) begin
      comm_flag <= 1'b1;
    end else if (clear_internal) begin
      comm_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Record bytes
  // ---------------------------------------------------------------------------
  always_comb begin
    module_info = diag_record_pkg::BYTE_ZERO;
    module_info[3:0] = diag_record_pkg::MODULE_CLASS_ANALOG;
    module_info[diag_record_pkg::MODINFO_CHAN_INFO_BIT] = 1'b1;
  end

  always_comb begin
    internal_diag = diag_record_pkg::BYTE_ZERO;
    internal_diag[diag_record_pkg::INTDIAG_OVERFLOW_BIT] = overflow_flag;
    internal_diag[diag_record_pkg::INTDIAG_COMM_BIT] = comm_flag;
  end

  always_comb begin
    channel_type = diag_record_pkg::BYTE_ZERO;
    channel_type[6:0] = diag_record_pkg::CHANNEL_TYPE_AO;
  end

  always_comb begin
    group_errors = diag_record_pkg::BYTE_ZERO;
    group_errors[N-1:0] = channel_any;
  end

  always_comb begin
    general_diag = diag_record_pkg::BYTE_ZERO;
    general_diag[diag_record_pkg::GEN_INTERNAL_BIT] = overflow_flag | comm_flag;
    general_diag[diag_record_pkg::GEN_EXTERNAL_BIT] = |short_sync;
    general_diag[diag_record_pkg::GEN_CHANNEL_BIT] = |channel_any;
    general_diag[diag_record_pkg::GEN_PARAM_BIT] = |cfg_sync;
    general_diag[diag_record_pkg::GEN_ANY_ERROR_BIT] =
      overflow_flag | comm_flag | (|channel_any);
  end

  // ---------------------------------------------------------------------------
  // Event timestamp
  // ---------------------------------------------------------------------------
  assign error_vector = {buffer_overflow, comm_error, short_sync, cfg_sync};
  assign new_event = |(error_vector & ~error_prev);

  always_ff @(posedge clk) begin
    if (reset) begin
      error_prev <= '0;
    end else begin
      error_prev <= error_vector;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      diag_timestamp <= '0;
    end else if (new_event) begin
      diag_timestamp <= ticker;
    end
  end

  // ---------------------------------------------------------------------------
  // Indicators
  // ---------------------------------------------------------------------------
  // channel indicator drive
  always_ff @(posedge clk) begin
    if (reset) begin
      channel_led <= '0;
      group_led <= 1'b0;
    end else begin
      channel_led <= channel_any;
      group_led <= general_diag[diag_record_pkg::GEN_ANY_ERROR_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Record read port
  // ---------------------------------------------------------------------------
  // short and full records
  assign set_ok = (req.record_set == diag_record_pkg::RECORD_SET_FULL) ||
                  (req.record_set == diag_record_pkg::RECORD_SET_SHORT);
  assign index_ok = (req.record_set == diag_record_pkg::RECORD_SET_FULL) ?
                    (req.index < diag_record_pkg::FULL_RECORD_LEN) :
                    (req.index < diag_record_pkg::SHORT_RECORD_LEN);
  assign accept_read = req_valid && !req.write && set_ok && index_ok;
  assign clear_internal = accept_read && (req.index == diag_record_pkg::IDX_INTERNAL_DIAG);

  always_comb begin
    next_data = diag_record_pkg::BYTE_ZERO;
    if (accept_read) begin
      unique case (req.index)
        diag_record_pkg::IDX_GENERAL_DIAG: begin
          next_data = general_diag;
        end
        diag_record_pkg::IDX_MODULE_INFO: begin
          next_data = module_info;
        end
        diag_record_pkg::IDX_INTERNAL_DIAG: begin
          next_data = internal_diag;
        end
        diag_record_pkg::IDX_CHANNEL_TYPE: begin
          next_data = channel_type;
        end
        diag_record_pkg::IDX_DIAG_BITS: begin
          next_data = diag_record_pkg::DIAG_BITS_PER_CHANNEL;
        end
        diag_record_pkg::IDX_CHANNEL_COUNT: begin
          next_data = diag_record_pkg::CHANNEL_COUNT;
        end
        diag_record_pkg::IDX_GROUP_ERRORS: begin
          next_data = group_errors;
        end
        diag_record_pkg::IDX_TIMESTAMP_0: begin
          next_data = diag_timestamp[7:0];
        end
        diag_record_pkg::IDX_TIMESTAMP_1: begin
          next_data = diag_timestamp[15:8];
        end
        diag_record_pkg::IDX_TIMESTAMP_2: begin
          next_data = diag_timestamp[23:16];
        end
        diag_record_pkg::IDX_TIMESTAMP_3: begin
          next_data = diag_timestamp[31:24];
        end
        default: begin
          if (req.index >= diag_record_pkg::IDX_CHANNEL_ERROR_0 &&
              req.index < diag_record_pkg::IDX_CHANNEL_ERROR_0 + 5'(N)) begin
            next_data = channel_error[req.index[1:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      resp_valid <= 1'b0;
      resp.data <= diag_record_pkg::BYTE_ZERO;
      resp.refused <= 1'b0;
    end else begin
      resp_valid <= req_valid;
      resp.data <= next_data;
      resp.refused <= req_valid && !accept_read;
    end
  end

endmodule : analog_output_diag_record

// file: verification/diag_record_assertions.sv
`timescale 1ns/100ps
module diag_record_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic [diag_record_pkg::NUM_CHANNELS-1:0] config_error,
  input wire logic [diag_record_pkg::NUM_CHANNELS-1:0] short_to_ground,
  input wire logic buffer_overflow,
  input wire logic comm_error,
  input wire logic req_valid,
  input wire diag_record_pkg::record_req_s req,
  input wire logic resp_valid,
  input wire diag_record_pkg::record_resp_s resp,
  input wire logic [diag_record_pkg::NUM_CHANNELS-1:0] channel_led,
  input wire logic group_led
);
  logic [diag_record_pkg::NUM_CHANNELS-1:0] pin_err;
  logic [2:0] steady;

  assign pin_err = config_error | short_to_ground;

  // Counts edges for which the error pins have not moved.
  // The count lags a pin change by one edge, so the checks also ask for stable pins.
  always_ff @(posedge clk) begin
    if (reset || !$stable(pin_err)) begin
      steady <= 3'h0;
    end else if (steady != 3'h7) begin
      steady <= steady + 3'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence asked(logic [4:0] i);
    req_valid && !req.write && req.record_set == 8'h01 && req.index == i;
  endsequence

  a_answer_next: assert property (req_valid |=> resp_valid)
    else $error("request got no answer");
  a_answer_only: assert property (!req_valid |=> !resp_valid)
    else $error("answer without request");
  a_module_class: assert property (asked(5'h01) |=> resp.data == 8'h15)
    else $error("module info byte wrong");
  a_channel_type: assert property (asked(5'h04) |=> resp.data == 8'h73)
    else $error("channel type byte wrong");
  a_diag_bits: assert property (asked(5'h05) |=> resp.data == 8'h08)
    else $error("diagnostic bit count wrong");
  a_channel_count: assert property (asked(5'h06) |=> resp.data == 8'h04)
    else $error("channel count wrong");
  a_write_refused: assert property (req_valid && req.write |=> resp == 9'h100)
    else $error("write not refused");
  a_short_limit: assert property (
    req_valid && req.record_set == 8'h00 && req.index >= 5'h04 |=> resp.refused)
    else $error("short record overrun not refused");
  a_group_errors: assert property (
    asked(5'h07) ##0 (steady >= 3'h4 && $stable(pin_err)) |=> resp.data == {4'h0, $past(pin_err)})
    else $error("group error byte wrong");
  a_led_follows: assert property (
    steady >= 3'h4 && $stable(pin_err) |-> channel_led == pin_err)
    else $error("channel indicator wrong");
endmodule : diag_record_assertions

bind analog_output_diag_record diag_record_assertions u_chk (.clk(clk), .reset(reset),
  .config_error(config_error), .short_to_ground(short_to_ground),
  .buffer_overflow(buffer_overflow), .comm_error(comm_error), .req_valid(req_valid),
  .req(req), .resp_valid(resp_valid), .resp(resp), .channel_led(channel_led),
  .group_led(group_led));

// file: verification/diag_reader.sv
`timescale 1ns/100ps
module diag_reader (
  input wire logic clk,
  output logic req_valid,
  output diag_record_pkg::record_req_s req,
  input wire logic resp_valid,
  input wire diag_record_pkg::record_resp_s resp
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  task automatic read_byte(input logic w, input logic [7:0] rs, input logic [4:0] idx,
                           output logic ok, output diag_record_pkg::record_resp_s r);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= {w, rs, idx};
    @(posedge clk);
    req_valid <= 1'b0;
    req <= {~w, ~rs, ~idx};
    @(posedge clk);
    ok = resp_valid;
    r = resp;
  endtask : read_byte
endmodule : diag_reader

// file: verification/tb_analog_output_diag_record.sv
`timescale 1ns/100ps
module tb_analog_output_diag_record;
  logic clk = 1'b0;
  logic reset;
  logic [3:0] config_error;
  logic [3:0] short_to_ground;
  logic buffer_overflow;
  logic comm_error;
  logic req_valid;
  diag_record_pkg::record_req_s req;
  logic resp_valid;
  diag_record_pkg::record_resp_s resp;
  logic [3:0] channel_led;
  logic group_led;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  analog_output_diag_record dut (.clk(clk), .reset(reset), .config_error(config_error),
    .short_to_ground(short_to_ground), .buffer_overflow(buffer_overflow),
    .comm_error(comm_error), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
    .resp(resp), .channel_led(channel_led), .group_led(group_led));

  diag_reader reader (.clk(clk), .req_valid(req_valid), .req(req),
    .resp_valid(resp_valid), .resp(resp));

  always #25 clk = ~clk;

  task automatic final_report;
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic w, input logic [7:0] rs, input logic [4:0] idx,
                    input logic [8:0] exp);
    logic ok;
    diag_record_pkg::record_resp_s r;
    reader.read_byte(w, rs, idx, ok, r);
    check({22'h0, ok, r}, {22'h0, 1'b1, exp});
  endtask : rd

  task automatic do_reset;
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  endtask : do_reset

  task automatic t_fixed_bytes;
    rd(1'b0, 8'h01, 5'h01, 9'h015);
    rd(1'b0, 8'h00, 5'h01, 9'h015);
    rd(1'b0, 8'h01, 5'h04, 9'h073);
    rd(1'b0, 8'h01, 5'h05, 9'h008);
    rd(1'b0, 8'h01, 5'h06, 9'h004);
    rd(1'b0, 8'h01, 5'h02, 9'h000);
    for (int i = 12; i < 16; i++) begin
      rd(1'b0, 8'h01, 5'(i), 9'h000);
    end
  endtask : t_fixed_bytes

  task automatic t_refusals;
    rd(1'b1, 8'h01, 5'h01, 9'h100);
    rd(1'b0, 8'h02, 5'h00, 9'h100);
    rd(1'b0, 8'h00, 5'h04, 9'h100);
    rd(1'b0, 8'h01, 5'h14, 9'h100);
    rd(1'b0, 8'h01, 5'h01, 9'h015);
  endtask : t_refusals

  task automatic t_channels;
    for (int ch = 0; ch < 4; ch++) begin
      @(posedge clk);
      config_error <= 4'h1 << ch;
      repeat (4) @(posedge clk);
      check(channel_led, 4'h1 << ch);
      check(group_led, 1'b1);
      rd(1'b0, 8'h01, 5'h08 + 5'(ch), 9'h001);
      rd(1'b0, 8'h01, 5'h07, 9'h001 << ch);
      rd(1'b0, 8'h01, 5'h00, 9'h089);
      @(posedge clk);
      config_error <= 4'h0;
      short_to_ground <= 4'h1 << ch;
      repeat (4) @(posedge clk);
      rd(1'b0, 8'h01, 5'h08 + 5'(ch), 9'h008);
      check(channel_led, 4'h1 << ch);
      rd(1'b0, 8'h01, 5'h00, 9'h00D);
      @(posedge clk);
      short_to_ground <= 4'h0;
    end
    repeat (4) @(posedge clk);
    rd(1'b0, 8'h01, 5'h07, 9'h000);
  endtask : t_channels

  task automatic t_internal;
    @(posedge clk);
    buffer_overflow <= 1'b1;
    @(posedge clk);
    buffer_overflow <= 1'b0;
    rd(1'b0, 8'h01, 5'h03, 9'h008);
    rd(1'b0, 8'h01, 5'h03, 9'h000);
    comm_error <= 1'b1;
    @(posedge clk);
    comm_error <= 1'b0;
    rd(1'b0, 8'h00, 5'h03, 9'h010);
  endtask : t_internal

  task automatic t_timestamp;
    logic [31:0] ts;
    logic ok;
    diag_record_pkg::record_resp_s r;
    do_reset;
    repeat (200) @(posedge clk);
    config_error <= 4'h2;
    repeat (4) @(posedge clk);
    for (int b = 0; b < 4; b++) begin
      reader.read_byte(1'b0, 8'h01, 5'h10 + 5'(b), ok, r);
      ts[8*b +: 8] = r.data;
    end
    check(ts >= 32'h9 && ts <= 32'hB, 1'b1);
    repeat (100) @(posedge clk);
    rd(1'b0, 8'h01, 5'h10, {1'b0, ts[7:0]});
    config_error <= 4'h0;
  endtask : t_timestamp

  initial begin
    reset = 1'b1;
    config_error = 4'h0;
    short_to_ground = 4'h0;
    buffer_overflow = 1'b0;
    comm_error = 1'b0;
    do_reset;
    t_fixed_bytes;
    t_refusals;
    t_channels;
    t_internal;
    t_timestamp;
    final_report;
  end
endmodule : tb_analog_output_diag_record
